// ### core/dsr_pkg.sv
package dsr_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int SIG_COUNT  = 4;
    localparam int SLOT_COUNT = 15;
    localparam int ID_W       = 10;
    localparam int PRI_W      = 4;

    // ****************************************
    // Parameter selector codes
    // ****************************************
    localparam logic [5:0] SEL_MAP_BASE  = 6'h00;
    localparam logic [5:0] SEL_PRI_BASE  = 6'h04;
    localparam logic [5:0] SEL_SUPPRESS  = 6'h08;
    localparam logic [5:0] SEL_DET_BASE  = 6'h10;
    localparam logic [5:0] SEL_BC_BASE   = 6'h20;
    localparam logic [5:0] SEL_KIND_MASK = 6'h30;

    // ****************************************
    // Map layout and reset values
    // ****************************************
    localparam logic [4:0]  RANGE_TOP_BIT  = 5'h1f;
    localparam logic [31:0] MAP_WRITE_MASK = 32'hffff_fffe;
    localparam logic [31:0] FAIL_MAP_RST   = 32'hf000_0000;
    localparam logic [31:0] CHECK_MAP_RST  = 32'h0f00_0000;
    localparam logic [31:0] OFFSPEC_MAP_RST = 32'h00f0_0000;
    localparam logic [31:0] MAINT_MAP_RST  = 32'h000f_0000;
    localparam logic [31:0] SUPPRESS_RST   = 32'h0000_0000;

    // ****************************************
    // Priorities and slot entries
    // ****************************************
    localparam logic [3:0] PRI_RST        = 4'h0;
    localparam logic [3:0] PRI_DISPLAY_MIN = 4'h1;
    localparam logic [3:0] PRI_BCAST_MIN  = 4'h2;
    localparam logic [3:0] PRI_BCAST_MAX  = 4'hf;
    localparam int         SLOT_EN_BIT    = 15;

    typedef enum logic [3:0] {
        DSR_SIG_NONE    = 4'b0000,
        DSR_SIG_FAIL    = 4'b0001,
        DSR_SIG_CHECK   = 4'b0010,
        DSR_SIG_OFFSPEC = 4'b0100,
        DSR_SIG_MAINT   = 4'b1000
    } dsr_sig_e;

    typedef struct packed {
        logic [ID_W-1:0] id;
        logic [3:0]      range;
    } dsr_evt_s;

    typedef struct packed {
        dsr_sig_e        sig;
        logic [ID_W-1:0] id;
        logic            display;
        logic            broadcast;
    } dsr_rep_s;

endpackage

// ### core/dsr_slot_match.sv
`timescale 1ns/1ps
`default_nettype none
module dsr_slot_match
    import dsr_pkg::*;
#(
    parameter int SLOTS = SLOT_COUNT,
    parameter int IDW   = ID_W
) (
    // Event
    input  wire logic [IDW-1:0]       evt_id,
    // Slot table
    input  wire logic [SLOTS:1]       slot_en,
    input  wire logic [SLOTS*IDW-1:0] slot_ids,
    // Result
    output logic      [SLOTS:1]       hit
);

    genvar k;
    generate
        for (k = 1; k <= SLOTS; k++) begin : g_slot
            assign hit[k] = slot_en[k] && (slot_ids[(k-1)*IDW +: IDW] == evt_id);
        end
    endgenerate

endmodule
`default_nettype wire

// ### core/dsr_prio_gate.sv
`timescale 1ns/1ps
`default_nettype none
module dsr_prio_gate
    import dsr_pkg::*;
(
    // Routing result
    input  wire logic [PRI_W-1:0] pri,
    input  wire logic             routed,
    input  wire logic             suppressed,
    input  wire logic             bc_allowed,
    // Decision
    output logic                  display,
    output logic                  broadcast
);

    // Zero ignores, one shows locally only, two and up also go out
    assign display   = routed && (pri >= PRI_DISPLAY_MIN);
    assign broadcast = routed && bc_allowed && !suppressed
                       && (pri >= PRI_BCAST_MIN) && (pri <= PRI_BCAST_MAX);

endmodule
`default_nettype wire

// ### core/dsr_router.sv
`timescale 1ns/1ps
`default_nettype none
module dsr_router
    import dsr_pkg::*;
#(
    parameter int SLOTS = SLOT_COUNT
) (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // Block mode
    input  wire logic        OUT_OF_SERVICE_MODE,
    // Parameter access
    input  wire logic        PARAM_WR,
    input  wire logic [5:0]  PARAM_SEL,
    input  wire logic [31:0] PARAM_WDATA,
    output logic      [31:0] PARAM_RDATA,
    // Diagnostic events
    input  wire logic        EVT_VALID,
    input  wire dsr_evt_s    EVT,
    // Reports
    output logic             REP_VALID,
    output dsr_rep_s         REP
);

    // ****************************************
    // Parameter store
    // ****************************************
    logic [SIG_COUNT-1:0][31:0]      map_r;
    logic [SIG_COUNT-1:0][PRI_W-1:0] pri_r;
    logic [31:0]                     suppress_r;
    logic [SLOTS:1]                  det_en_r;
    logic [SLOTS*ID_W-1:0]           det_ids_r;
    logic [SLOTS:1]                  bc_en_r;
    logic [SLOTS*ID_W-1:0]           bc_ids_r;

    logic [5:0] sel_kind;
    logic [3:0] sel_idx;
    logic       map_wr;
    logic       pri_wr;

    assign sel_kind = PARAM_SEL & SEL_KIND_MASK;
    assign sel_idx  = PARAM_SEL[3:0];
    // Maps may only change while the block is out of service; slot bindings can change at any time
    assign map_wr = PARAM_WR && OUT_OF_SERVICE_MODE && (sel_kind == SEL_MAP_BASE)
                    && (sel_idx < 4'(SIG_COUNT));
    assign pri_wr = PARAM_WR && (sel_kind == SEL_MAP_BASE) && (sel_idx >= 4'(SIG_COUNT))
                    && (sel_idx < 4'(2 * SIG_COUNT));

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            map_r[0] <= FAIL_MAP_RST;
            map_r[1] <= CHECK_MAP_RST;
            map_r[2] <= OFFSPEC_MAP_RST;
            map_r[3] <= MAINT_MAP_RST;
        end else if (map_wr) begin
            map_r[sel_idx[1:0]] <= PARAM_WDATA & MAP_WRITE_MASK;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pri_r <= {SIG_COUNT{PRI_RST}};
        end else if (pri_wr) begin
            pri_r[sel_idx[1:0]] <= PARAM_WDATA[PRI_W-1:0];
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            suppress_r <= SUPPRESS_RST;
        end else if (PARAM_WR && PARAM_SEL == SEL_SUPPRESS) begin
            suppress_r <= PARAM_WDATA & MAP_WRITE_MASK;
        end
    end

    // Slot bindings: selector low nibble 1..15 picks the slot
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            det_en_r  <= '0;
            det_ids_r <= '0;
            bc_en_r   <= '0;
            bc_ids_r  <= '0;
        end else if (PARAM_WR && sel_idx != 4'h0) begin
            if (sel_kind == SEL_DET_BASE) begin
                det_en_r[sel_idx] <= PARAM_WDATA[SLOT_EN_BIT];
                det_ids_r[(32'(sel_idx) - 1) * ID_W +: ID_W] <= PARAM_WDATA[ID_W-1:0];
            end
            if (sel_kind == SEL_BC_BASE) begin
                bc_en_r[sel_idx] <= PARAM_WDATA[SLOT_EN_BIT];
                bc_ids_r[(32'(sel_idx) - 1) * ID_W +: ID_W] <= PARAM_WDATA[ID_W-1:0];
            end
        end
    end

    // ****************************************
    // Read back
    // ****************************************
    logic [31:0] rd_nxt;

    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (sel_kind)
            SEL_MAP_BASE: begin
                if (sel_idx < 4'(SIG_COUNT)) begin
                    rd_nxt = map_r[sel_idx[1:0]];
                end else if (sel_idx < 4'(2 * SIG_COUNT)) begin
                    rd_nxt = {28'h0, pri_r[sel_idx[1:0]]};
                end else if (PARAM_SEL == SEL_SUPPRESS) begin
                    rd_nxt = suppress_r;
                end
            end
            SEL_DET_BASE: begin
                if (sel_idx != 4'h0) begin
                    rd_nxt[SLOT_EN_BIT] = det_en_r[sel_idx];
                    rd_nxt[ID_W-1:0]    = det_ids_r[(32'(sel_idx) - 1) * ID_W +: ID_W];
                end
            end
            SEL_BC_BASE: begin
                if (sel_idx != 4'h0) begin
                    rd_nxt[SLOT_EN_BIT] = bc_en_r[sel_idx];
                    rd_nxt[ID_W-1:0]    = bc_ids_r[(32'(sel_idx) - 1) * ID_W +: ID_W];
                end
            end
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PARAM_RDATA <= 32'h0000_0000;
        end else begin
            PARAM_RDATA <= rd_nxt;
        end
    end

    // ****************************************
    // Event routing
    // ****************************************
    logic [SLOTS:1]         det_hit;
    logic [SLOTS:1]         bc_hit;
    logic [4:0]             range_bit;
    logic [SIG_COUNT-1:0]   range_hit;
    logic [SIG_COUNT-1:0]   sig_hit;
    logic [SIG_COUNT-1:0]   chosen;
    logic [PRI_W-1:0]       sel_pri;
    logic                   routed;
    logic                   sel_range;
    logic                   bc_allowed;
    logic                   suppressed;
    logic                   display;
    logic                   broadcast;

    dsr_slot_match #(.SLOTS(SLOTS), .IDW(ID_W)) u_det_match (
        .evt_id   (EVT.id),
        .slot_en  (det_en_r),
        .slot_ids (det_ids_r),
        .hit      (det_hit)
    );

    dsr_slot_match #(.SLOTS(SLOTS), .IDW(ID_W)) u_bc_match (
        .evt_id   (EVT.id),
        .slot_en  (bc_en_r),
        .slot_ids (bc_ids_r),
        .hit      (bc_hit)
    );

    assign range_bit = RANGE_TOP_BIT - {1'b0, EVT.range};

    always_comb begin
        for (int s = 0; s < SIG_COUNT; s++) begin
            range_hit[s] = map_r[s][range_bit];
            sig_hit[s]   = range_hit[s] || |(map_r[s][SLOTS:1] & (det_hit | bc_hit));
        end
    end

    // Several maps may claim one event; the most severe signal wins
    always_comb begin
        chosen     = '0;
        sel_pri    = PRI_RST;
        sel_range  = 1'b0;
        bc_allowed = 1'b0;
        suppressed = 1'b0;
        for (int s = SIG_COUNT - 1; s >= 0; s--) begin
            if (sig_hit[s]) begin
                chosen     = SIG_COUNT'(1) << s;
                sel_pri    = pri_r[s];
                sel_range  = range_hit[s];
                bc_allowed = range_hit[s] || |(map_r[s][SLOTS:1] & bc_hit);
                suppressed = (range_hit[s] && suppress_r[range_bit])
                             || |(suppress_r[SLOTS:1] & map_r[s][SLOTS:1]
                                  & (det_hit | bc_hit));
            end
        end
    end

    assign routed = |sig_hit;

    dsr_prio_gate u_gate (
        .pri        (sel_pri),
        .routed     (routed),
        .suppressed (suppressed),
        .bc_allowed (bc_allowed),
        .display    (display),
        .broadcast  (broadcast)
    );

    // Signal is fixed when the event occurs; later map changes leave it
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            REP_VALID <= 1'b0;
        end else begin
            REP_VALID <= EVT_VALID && routed;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            REP <= '{sig: DSR_SIG_NONE, id: '0, display: 1'b0, broadcast: 1'b0};
        end else if (EVT_VALID && routed) begin
            REP.sig       <= dsr_sig_e'(chosen);
            REP.id        <= EVT.id;
            REP.display   <= display;
            REP.broadcast <= broadcast;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // Report checks look one edge after the edge that took the event
    a_unmapped_silent: assert property (EVT_VALID && !routed |=> !REP_VALID)
        else $error("unmapped event produced a report");
    a_range_to_fail: assert property (
        EVT_VALID && map_r[0][range_bit] |=> REP_VALID && REP.sig == DSR_SIG_FAIL)
        else $error("failure-mapped range not reported as failure");
    a_range_to_check: assert property (
        EVT_VALID && map_r[1][range_bit] && !sig_hit[0] |=> REP.sig == DSR_SIG_CHECK)
        else $error("check-mapped range not reported as function check");
    a_slot_to_fail: assert property (
        EVT_VALID && |(map_r[0][SLOTS:1] & det_hit) |=> REP_VALID && REP.sig == DSR_SIG_FAIL)
        else $error("failure-mapped slot not reported as failure");
    a_sig_onehot: assert property (REP_VALID |-> $onehot(REP.sig))
        else $error("report carries no single status signal");
    a_zero_ignored: assert property (
        EVT_VALID && routed && sel_pri == 4'h0 |=> !REP.display && !REP.broadcast)
        else $error("priority zero event was shown or sent");
    a_one_local: assert property (
        EVT_VALID && routed && sel_pri == 4'h1 |=> REP.display && !REP.broadcast)
        else $error("priority one event handled wrongly");
    a_display_min: assert property (
        EVT_VALID && routed && sel_pri >= 4'h1 |=> REP.display)
        else $error("event with nonzero priority not shown");
    a_bcast_window: assert property (
        REP_VALID && REP.broadcast |-> $past(sel_pri) >= 4'h2)
        else $error("broadcast below priority two");
    a_range_bcast: assert property (
        EVT_VALID && sel_range && !suppressed && sel_pri >= 4'h2 |=> REP.broadcast)
        else $error("range event with bus priority not sent");
    a_bcast_allowed: assert property (
        EVT_VALID && bc_allowed && !suppressed && sel_pri >= 4'h2 |=> REP.broadcast)
        else $error("broadcast-enabled event not sent");
    a_slot_only_local: assert property (
        EVT_VALID && routed && !bc_allowed |=> !REP.broadcast)
        else $error("detection-only event sent on the bus");
    a_suppress_local: assert property (
        EVT_VALID && routed && suppressed && sel_pri != 4'h0 |=> !REP.broadcast && REP.display)
        else $error("suppressed event sent or not shown");
    a_report_held: assert property (
        !EVT_VALID ##1 !EVT_VALID |-> !REP_VALID && $stable(REP.sig))
        else $error("report changed without a new event");
    a_report_id: assert property (
        EVT_VALID && routed |=> REP_VALID && REP.id == $past(EVT.id))
        else $error("report names the wrong event");
    a_map_locked: assert property (!OUT_OF_SERVICE_MODE |=> $stable(map_r))
        else $error("map changed outside out of service mode");
    a_pri_held: assert property (!PARAM_WR |=> $stable(pri_r))
        else $error("priority changed without a write");
    a_slots_held: assert property (!PARAM_WR |=> $stable(det_en_r) && $stable(bc_en_r))
        else $error("slot binding changed without a write");
    a_bit0_reads: assert property (PARAM_SEL < SEL_PRI_BASE |=> !PARAM_RDATA[0])
        else $error("reserved map bit read as one");
    a_bit0_stored: assert property (
        !map_r[0][0] && !map_r[1][0] && !map_r[2][0] && !map_r[3][0])
        else $error("reserved map bit stored as one");

endmodule
`default_nettype wire

// ### verif/dsr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dsr_host_model (
    // Device clock
    input  wire logic        clk,
    // Parameter port
    output logic             out_of_service_mode,
    output logic             wr,
    output logic      [5:0]  sel,
    output logic      [31:0] wdata,
    input  wire logic [31:0] rdata
);
    initial begin
        out_of_service_mode   = 1'b0;
        wr    = 1'b0;
        sel   = 6'h00;
        wdata = 32'h0000_0000;
    end

    task automatic put(input logic [5:0] s, input logic [31:0] d);
        @(negedge clk);
        sel   = s;
        wdata = d;
        wr    = 1'b1;
        @(negedge clk);
        wr    = 1'b0;
        // Released data must not look valid
        wdata = ~d;
    endtask

    task automatic get(input logic [5:0] s, output logic [31:0] d);
        @(negedge clk);
        sel = s;
        @(negedge clk);
        d = rdata;
    endtask

    // Maps only change with the block out of service
    task automatic put_map(input logic [5:0] s, input logic [31:0] d);
        @(negedge clk);
        out_of_service_mode = 1'b1;
        put(s, d);
        @(negedge clk);
        out_of_service_mode = 1'b0;
    endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import dsr_pkg::*;
;
    logic        clk;
    logic        rst;
    logic        out_of_service_mode;
    logic        wr;
    logic [5:0]  sel;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        evt_valid;
    dsr_evt_s    evt;
    logic        rep_valid;
    dsr_rep_s    rep;
    int          n_fail;
    int          comparisons;
    int unsigned seed;
    logic [31:0] map_m [4];
    logic [3:0]  pri_m [4];
    logic [31:0] supp_m;
    logic [31:0] det_m [16];
    logic [31:0] bc_m [16];
    logic        exp_v;
    dsr_rep_s    exp_r;
    dsr_rep_s    last_r;

    dsr_router dsr_router_i (.CLK(clk), .RST(rst), .OUT_OF_SERVICE_MODE(out_of_service_mode),
        .PARAM_WR(wr), .PARAM_SEL(sel), .PARAM_WDATA(wdata), .PARAM_RDATA(rdata),
        .EVT_VALID(evt_valid), .EVT(evt), .REP_VALID(rep_valid), .REP(rep));
    dsr_host_model dsr_host_model_i (.clk(clk), .out_of_service_mode(out_of_service_mode), .wr(wr), .sel(sel),
        .wdata(wdata), .rdata(rdata));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****************************************
    // Checking helpers
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        comparisons++;
        if (got !== want) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, want);
        end
    endtask

    // Lowest signal index wins, so walk from maintenance up to failure
    function automatic void predict(input dsr_evt_s e, output logic v, output dsr_rep_s r);
        logic rh, dh, bh, sp;
        v = 1'b0;
        r = '0;
        for (int s = 3; s >= 0; s--) begin
            rh = map_m[s][31 - e.range];
            dh = 1'b0;
            bh = rh;
            sp = rh & supp_m[31 - e.range];
            for (int k = 1; k <= 15; k++) begin
                if (map_m[s][k] && det_m[k][15] && det_m[k][9:0] === e.id) begin
                    dh = 1'b1;
                    sp = sp | supp_m[k];
                end
                if (map_m[s][k] && bc_m[k][15] && bc_m[k][9:0] === e.id) begin
                    bh = 1'b1;
                    sp = sp | supp_m[k];
                end
            end
            if (rh | dh | bh) begin
                v = 1'b1;
                r.sig = dsr_sig_e'(4'h1 << s);
                r.id = e.id;
                r.display = pri_m[s] >= 4'h1;
                r.broadcast = pri_m[s] >= 4'h2 && bh && !sp;
            end
        end
    endfunction

    // Checks the previous cycle's event, then offers a new one
    task automatic step(input logic v, input dsr_evt_s e);
        logic     nv;
        dsr_rep_s nr;
        @(negedge clk);
        chk({31'h0, rep_valid}, {31'h0, exp_v});
        if (exp_v) begin
            chk({16'h0, rep}, {16'h0, exp_r});
            last_r = exp_r;
        end else begin
            chk({16'h0, rep}, {16'h0, last_r});
        end
        predict(e, nv, nr);
        exp_v = v & nv;
        exp_r = nr;
        evt_valid = v;
        evt = e;
    endtask

    task automatic set_param(input logic [5:0] s, input logic [31:0] d);
        step(1'b0, '0);
        if (s < 6'h04) begin
            dsr_host_model_i.put_map(s, d);
            map_m[s[1:0]] = d & 32'hffff_fffe;
        end else begin
            dsr_host_model_i.put(s, d);
            if (s < 6'h08) pri_m[s[1:0]] = d[3:0];
            else if (s == 6'h08) supp_m = d;
            else if (s[5:4] == 2'b01) det_m[s[3:0]] = d;
            else bc_m[s[3:0]] = d;
        end
    endtask

    task automatic read_chk(input logic [5:0] s, input logic [31:0] m, input logic [31:0] w);
        logic [31:0] d;
        step(1'b0, '0);
        dsr_host_model_i.get(s, d);
        chk(d & m, w & m);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        n_fail++;
        summarize();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [31:0] x;
        logic [3:0]  corner [4];
        rst = 1'b1;
        evt_valid = 1'b0;
        evt = '0;
        seed = 32'h2366441f;
        n_fail = 0;
        comparisons = 0;
        exp_v = 1'b0;
        exp_r = '0;
        last_r = '0;
        supp_m = 32'h0;
        corner = '{4'h0, 4'h1, 4'h2, 4'hf};
        map_m = '{32'hf000_0000, 32'h0f00_0000, 32'h00f0_0000, 32'h000f_0000};
        for (int i = 0; i < 16; i++) begin
            det_m[i] = 32'h0;
            bc_m[i] = 32'h0;
            if (i < 4) pri_m[i] = 4'h0;
        end
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 4; i++) read_chk(6'(i), 32'hffff_ffff, map_m[i]);
        for (int i = 4; i < 8; i++) read_chk(6'(i), 32'hf, 32'h0);
        for (int i = 0; i < 16; i++) step(1'b1, {10'(i * 37), 4'(i)});
        for (int i = 0; i < 4; i++) set_param(6'(4 + i), {28'h0, corner[i]});
        for (int i = 0; i < 16; i++) step(1'b1, {10'(i), 4'(i)});
        repeat (4) begin
            for (int i = 0; i < 4; i++) begin
                x = $random(seed);
                set_param(6'(4 + i), {28'h0, x[3:0]});
            end
            x = $random(seed);
            set_param(6'h08, x);
            repeat (40) begin
                x = $random(seed);
                step(x[20] | x[21], x[13:0]);
            end
        end
        for (int i = 0; i < 4; i++) set_param(6'(4 + i), 32'h7);
        set_param(6'h08, 32'h0);
        set_param(6'h00, map_m[0] & 32'hbfff_ffff);
        set_param(6'h01, map_m[1] | 32'h4000_0000);
        for (int i = 0; i < 8; i++) step(1'b1, {10'(i * 113), 4'h1});
        set_param(6'h02, map_m[2] & 32'hffbf_ffff);
        for (int i = 0; i < 4; i++) step(1'b1, {10'(i * 7), 4'h9});
        set_param(6'h02, map_m[2] | 32'h0040_0000);
        // Map write while in service must be dropped
        dsr_host_model_i.put(6'h00, 32'h0);
        read_chk(6'h00, 32'hffff_ffff, map_m[0]);
        set_param(6'h03, map_m[3] | 32'h1);
        read_chk(6'h03, 32'hffff_ffff, map_m[3]);
        set_param(6'h13, 32'h0000_8155);
        set_param(6'h25, 32'h0000_82aa);
        set_param(6'h00, map_m[0] | 32'h8);
        set_param(6'h01, map_m[1] | 32'h20);
        repeat (2) begin
            step(1'b1, {10'h155, 4'hc});
            step(1'b1, {10'h2aa, 4'hc});
        end
        set_param(6'h08, 32'h20);
        step(1'b1, {10'h2aa, 4'hc});
        step(1'b0, '0);
        step(1'b0, '0);
        summarize();
    end
endmodule
`default_nettype wire
